// file: common/pcsr_defs.svh
// Purpose: Offsets, field positions, reset values and byte masks of the slot registers.
// Assumes: Configuration offsets are byte addresses of aligned 32-bit words.
// Notes: Definitions only; included by bare name.
`ifndef PCSR_DEFS_SVH
`define PCSR_DEFS_SVH

// Register offsets in configuration space.
`define PCSR_OFF_SLOT_CAP 12'h0b4
`define PCSR_OFF_SLOT_CTL 12'h0b8

// Reset values.
`define PCSR_CAP_RESET 32'h0004_0000
`define PCSR_CTL_RESET 16'h0000

// Slot capabilities field positions.
`define PCSR_SLOTNUM_MSB 31
`define PCSR_SLOTNUM_LSB 19
`define PCSR_RSVD_ONE_BIT 18
`define PCSR_INTERLOCK_PRESENT_BIT 17
`define PCSR_SCALE_MSB 16
`define PCSR_SCALE_LSB 15
`define PCSR_VALUE_MSB 14
`define PCSR_VALUE_LSB 7
`define PCSR_POWER_IND_PRESENT_BIT 4
`define PCSR_ATTN_IND_PRESENT_BIT 3
`define PCSR_LATCH_SENSOR_PRESENT_BIT 2
`define PCSR_PWR_CTRL_PRESENT_BIT 1
`define PCSR_ATTN_BUTTON_PRESENT_BIT 0

// Slot control field positions.
`define PCSR_CTL_RSVD_MSB 15
`define PCSR_CTL_RSVD_LSB 13
`define PCSR_NOTIFY_EN_BIT 12
`define PCSR_TOGGLE_BIT 11
`define PCSR_PWR_CTL_BIT 10

// Byte lanes that overlap each writable field.
`define PCSR_BE_SLOTNUM 4'hc
`define PCSR_BE_SCALE 4'h6
`define PCSR_BE_VALUE 4'h3
`define PCSR_BE_CTL 4'h2

`endif

// file: common/pcsr_pkg.sv
// Purpose: Types shared by the slot register bank and its message requester.
// Assumes: Constants live in pcsr_defs.svh.
// Notes: None.
`default_nettype none

package pcsr_pkg;

  // Power limit scale encodings.
  typedef enum logic [1:0] {
    pcsr_scale_1x = 2'h0,
    pcsr_scale_0p1x = 2'h1,
    pcsr_scale_0p01x = 2'h2,
    pcsr_scale_0p001x = 2'h3
  } pcsr_scale_type;

  // Whole state of the register bank.
  typedef struct packed {
    logic [12:0] slot_num;
    pcsr_scale_type scale;
    logic [7:0] limit;
    logic slot_num_lock;
    logic scale_lock;
    logic limit_lock;
    logic notify_en;
    logic pwr_off;
    logic pwr_fault;
    logic link_prev;
    logic notify;
    logic toggle;
    logic msg_send;
    logic [31:0] rdata;
    logic rvalid;
  } pcsr_state_type;

  // Whole state of the message requester.
  typedef struct packed {
    logic valid;
    logic again;
    logic [7:0] value;
    pcsr_scale_type scale;
  } pcsr_msg_state_type;

endpackage

`default_nettype wire

// file: hw/pcsr_msg.sv
// Purpose: Holds a Set_Slot_Power_Limit request until the link accepts it.
// Assumes: The link takes a request in a cycle where valid and ready are both high.
// Notes: A send during a pending request is remembered and re-sent with fresh values.
`timescale 1ns/10ps
`default_nettype none
`include "pcsr_defs.svh"

module pcsr_msg
  import pcsr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Request from the register bank.
  input wire logic send,
  input wire logic [7:0] value,
  input var pcsr_scale_type scale,
  // Link message request.
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [7:0] msg_value,
  output pcsr_scale_type msg_scale
);

  pcsr_msg_state_type st_r;
  pcsr_msg_state_type st_nxt;

  // Load, hold and retire the request; a new send always wins over retirement.
  always_comb begin
    st_nxt = st_r;
    if (st_r.valid && msg_ready) begin
      st_nxt.valid = st_r.again;
      st_nxt.again = 1'b0;
      st_nxt.value = value;
      st_nxt.scale = scale;
    end
    if (send) begin
      if (st_nxt.valid) begin
        st_nxt.again = 1'b1;
      end else begin
        st_nxt.valid = 1'b1;
        st_nxt.value = value;
        st_nxt.scale = scale;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign msg_valid = st_r.valid;
  assign msg_value = st_r.value;
  assign msg_scale = st_r.scale;

  // A pending request stays up with stable data until accepted.
  AST_MSG_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    msg_valid && !msg_ready |=> msg_valid && $stable(msg_value) && $stable(msg_scale))
    else $error("Power limit message dropped before acceptance.");

endmodule // pcsr_msg

`default_nettype wire

// file: hw/pcsr_regs.sv
// Purpose: Slot capabilities and slot control registers of a root port link.
// Assumes: Configuration accesses are single-cycle strobes on the core clock.
// Notes: Read data returns one cycle after the read strobe, with rvalid.
//
// Contract
// - Slot number is write-once at bits 31:19, zero after reset.
// - Capabilities reset to 00040000h; reserved bit 18 reads one.
// - Bit 17 reads zero: no electromechanical interlock.
// - Write-once power limit scale at bits 16:15, four decimal scales.
// - Write-once eight-bit power limit value at bits 14:7.
// - Writing scale or value sends a Set_Slot_Power_Limit message.
// - Bit 4 reads zero: no power indicator.
// - Bit 3 reads zero: no attention indicator.
// - Bits 2, 1 and 0 read zero.
// - Slot control resets to 0000h; bits 15:13 read zero.
// - Bit 12 enables notice on link-active change, else reads zero.
// - Writing one to bit 11 toggles the interlock; zero does nothing.
// - Bit 11 always reads zero.
// - Bit 10 sets slot power: zero on, one off.
// - Bit 10 reads back the latest written value.
// - A detected fault removes slot power regardless of bit 10.
// - Without a power controller, writes to bit 10 are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "pcsr_defs.svh"

module pcsr_regs
  import pcsr_pkg::*;
#(
  parameter bit LINK_ACTIVE_CAP = 1'b0,
  parameter bit INTERLOCK_PRESENT = 1'b0,
  parameter bit PWR_CTRL_PRESENT = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Configuration access port.
  input wire logic [11:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // Link status and notification.
  input wire logic link_active,
  output logic link_change_event,
  // Slot hardware.
  output logic interlock_toggle,
  input wire logic pwr_fault,
  output logic slot_power_en,
  // Set_Slot_Power_Limit message request.
  output logic spl_msg_valid,
  input wire logic spl_msg_ready,
  output logic [7:0] spl_msg_value,
  output pcsr_scale_type spl_msg_scale
);

  ////////////////////////////////////////////////////////////////////////////////////////////

  // Merges write data into the current word byte by byte.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Builds the slot capabilities word; presence bits stay at their reset zero.
  function automatic logic [31:0] cap_word(input pcsr_state_type s);
    logic [31:0] w;
    w = `PCSR_CAP_RESET;
    w[`PCSR_SLOTNUM_MSB:`PCSR_SLOTNUM_LSB] = s.slot_num;
    w[`PCSR_SCALE_MSB:`PCSR_SCALE_LSB] = s.scale;
    w[`PCSR_VALUE_MSB:`PCSR_VALUE_LSB] = s.limit;
    return w;
  endfunction

  // Builds the slot control word; the upper half belongs to slot status, not held here.
  function automatic logic [31:0] ctl_word(input pcsr_state_type s);
    logic [31:0] w;
    w = {16'h0000, `PCSR_CTL_RESET};
    w[`PCSR_NOTIFY_EN_BIT] = s.notify_en;
    w[`PCSR_PWR_CTL_BIT] = s.pwr_off;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////

  pcsr_state_type st_r;
  pcsr_state_type st_nxt;
  logic cap_hit;
  logic ctl_hit;
  logic cap_wr;
  logic ctl_wr;
  logic [31:0] cap_merged;

  // Address decode on the aligned word.
  assign cap_hit = (cfg_addr[11:2] == 10'(`PCSR_OFF_SLOT_CAP >> 2));
  assign ctl_hit = (cfg_addr[11:2] == 10'(`PCSR_OFF_SLOT_CTL >> 2));
  assign cap_wr = cfg_wr && cap_hit;
  assign ctl_wr = cfg_wr && ctl_hit && |(cfg_be & `PCSR_BE_CTL);
  assign cap_merged = be_merge(cap_word(st_r), cfg_wdata, cfg_be);

  // Next-state logic for fields, slot actions and read data.
  always_comb begin
    st_nxt = st_r;
    st_nxt.notify = 1'b0;
    st_nxt.toggle = 1'b0;
    st_nxt.msg_send = 1'b0;
    st_nxt.rvalid = cfg_rd;
    st_nxt.link_prev = link_active;
    // Write-once fields lock on the first write that touches them.
    if (cap_wr && |(cfg_be & `PCSR_BE_SLOTNUM) && !st_r.slot_num_lock) begin
      st_nxt.slot_num = cap_merged[`PCSR_SLOTNUM_MSB:`PCSR_SLOTNUM_LSB];
      st_nxt.slot_num_lock = 1'b1;
    end
    if (cap_wr && |(cfg_be & `PCSR_BE_SCALE) && !st_r.scale_lock) begin
      st_nxt.scale = pcsr_scale_type'(cap_merged[`PCSR_SCALE_MSB:`PCSR_SCALE_LSB]);
      st_nxt.scale_lock = 1'b1;
    end
    if (cap_wr && |(cfg_be & `PCSR_BE_VALUE) && !st_r.limit_lock) begin
      st_nxt.limit = cap_merged[`PCSR_VALUE_MSB:`PCSR_VALUE_LSB];
      st_nxt.limit_lock = 1'b1;
    end
    // Any write to the power limit fields reports the held limit to the adapter.
    if (cap_wr && |(cfg_be & (`PCSR_BE_SCALE | `PCSR_BE_VALUE))) begin
      st_nxt.msg_send = 1'b1;
    end
    // Slot control bits live in byte lane one.
    if (ctl_wr) begin
      if (LINK_ACTIVE_CAP) begin
        st_nxt.notify_en = cfg_wdata[`PCSR_NOTIFY_EN_BIT];
      end
      if (INTERLOCK_PRESENT) begin
        st_nxt.toggle = cfg_wdata[`PCSR_TOGGLE_BIT];
      end
      if (PWR_CTRL_PRESENT) begin
        st_nxt.pwr_off = cfg_wdata[`PCSR_PWR_CTL_BIT];
        if (cfg_wdata[`PCSR_PWR_CTL_BIT]) begin
          st_nxt.pwr_fault = 1'b0;
        end
      end
    end
    // A fault latches after the clear so that it is never lost.
    if (PWR_CTRL_PRESENT && pwr_fault) begin
      st_nxt.pwr_fault = 1'b1;
    end
    // Notify on either edge of link-active while enabled.
    if (LINK_ACTIVE_CAP && st_r.notify_en && (link_active != st_r.link_prev)) begin
      st_nxt.notify = 1'b1;
    end
    // Read data; unmapped offsets read zero.
    if (cfg_rd) begin
      if (cap_hit) begin
        st_nxt.rdata = cap_word(st_r);
      end else if (ctl_hit) begin
        st_nxt.rdata = ctl_word(st_r);
      end else begin
        st_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////

  // Output assignments.
  assign cfg_rdata = st_r.rdata;
  assign cfg_rvalid = st_r.rvalid;
  assign link_change_event = st_r.notify;
  assign interlock_toggle = st_r.toggle;
  // Power flows only on request and while no fault is latched.
  assign slot_power_en = PWR_CTRL_PRESENT && !st_r.pwr_off && !st_r.pwr_fault;

  // Message requester for the power limit.
  pcsr_msg u_msg (
    .clk(clk),
    .reset_n(reset_n),
    .send(st_r.msg_send),
    .value(st_r.limit),
    .scale(st_r.scale),
    .msg_valid(spl_msg_valid),
    .msg_ready(spl_msg_ready),
    .msg_value(spl_msg_value),
    .msg_scale(spl_msg_scale)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////

  // Locked fields never change again.
  AST_SLOTNUM_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
    st_r.slot_num_lock |=> st_r.slot_num_lock && $stable(st_r.slot_num))
    else $error("Slot number changed after its first write.");

  AST_SCALE_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
    st_r.scale_lock |=> $stable(st_r.scale))
    else $error("Power limit scale changed after its first write.");

  AST_LIMIT_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
    st_r.limit_lock |=> $stable(st_r.limit))
    else $error("Power limit value changed after its first write.");

  // A first full-word write to the value field takes bits 14:7 of the write data.
  AST_LIMIT_TAKE: assert property (@(posedge clk) disable iff (!reset_n)
    cap_wr && cfg_be == 4'hf && !st_r.limit_lock |=>
    st_r.limit == $past(cfg_wdata[14:7]))
    else $error("Power limit value not taken on first write.");

  // Capabilities reads show bit 18 set and every presence bit clear.
  AST_CAP_READ: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_rd && cap_hit |=> cfg_rvalid && cfg_rdata[18] && cfg_rdata[17] == 1'b0 &&
    cfg_rdata[6:0] == 7'h00)
    else $error("Slot capabilities read shows wrong fixed bits.");

  // A power limit write raises a message request within two cycles.
  AST_MSG_ON_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
    cap_wr && |(cfg_be & 4'h7) |-> ##[1:2] spl_msg_valid)
    else $error("Power limit write did not request a message.");

  // Slot control reads keep reserved and toggle bits at zero.
  AST_CTL_READ: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_rd && ctl_hit |=> cfg_rdata[15:13] == 3'h0 && cfg_rdata[11] == 1'b0 &&
    cfg_rdata[9:0] == 10'h000)
    else $error("Slot control read shows set reserved or toggle bits.");

  // Link-active change while enabled gives a notice one cycle later.
  AST_NOTIFY: assert property (@(posedge clk) disable iff (!reset_n)
    LINK_ACTIVE_CAP && st_r.notify_en && (link_active != st_r.link_prev) |=> link_change_event)
    else $error("Link-active change produced no notice.");

  // A toggle pulse comes only from a write of one to the toggle bit.
  AST_TOGGLE: assert property (@(posedge clk) disable iff (!reset_n)
    interlock_toggle |-> INTERLOCK_PRESENT && $past(ctl_wr && cfg_wdata[11]))
    else $error("Interlock toggled without a write of one.");

  // Power control read two cycles after a write, with no write between, shows that write.
  AST_PWR_READBACK: assert property (@(posedge clk) disable iff (!reset_n)
    PWR_CTRL_PRESENT && ctl_wr ##1 !ctl_wr ##1 cfg_rd && ctl_hit |=>
    cfg_rdata[10] == $past(cfg_wdata[10], 3))
    else $error("Power control bit does not read back the last write.");

  // Without a controller the power bit never moves.
  AST_PWR_IGNORED: assert property (@(posedge clk) disable iff (!reset_n)
    !PWR_CTRL_PRESENT |-> !st_r.pwr_off && !slot_power_en)
    else $error("Power control moved without a power controller.");

  // A fault removes power on the next cycle whatever was requested.
  AST_FAULT_OFF: assert property (@(posedge clk) disable iff (!reset_n)
    pwr_fault |=> !slot_power_en)
    else $error("Slot power stayed on after a fault.");

  // Power on request with no fault gives power.
  AST_PWR_ON: assert property (@(posedge clk) disable iff (!reset_n)
    PWR_CTRL_PRESENT && ctl_wr && !cfg_wdata[10] && !pwr_fault && !st_r.pwr_fault |=>
    slot_power_en)
    else $error("Power on request did not enable slot power.");

endmodule // pcsr_regs

`default_nettype wire

// file: verif/pcsr_link_model.sv
// Purpose: Far end of the link that takes Set_Slot_Power_Limit requests.
// Assumes: A request is taken at a rising edge with valid and ready both high.
// Notes: Ready stays low for stall plus one cycles once a request shows.
`timescale 1ns/10ps
`default_nettype none

module pcsr_link_model
  import pcsr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Message request from the port.
  input wire logic msg_valid,
  output logic msg_ready,
  input wire logic [7:0] msg_value,
  input var pcsr_scale_type msg_scale,
  // Bench control and record of accepted messages.
  input wire logic [3:0] stall,
  output logic [7:0] rx_count,
  output logic [7:0] rx_value,
  output logic [1:0] rx_scale
);
  logic [3:0] wait_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Ready is raised only after the stall has run, and dropped after each take.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msg_ready <= 1'b0;
      wait_cnt <= 4'h0;
      rx_count <= 8'h00;
      rx_value <= 8'h00;
      rx_scale <= 2'h0;
    end else if (msg_valid && msg_ready) begin
      rx_count <= rx_count + 8'h01;
      rx_value <= msg_value;
      rx_scale <= msg_scale;
      msg_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (msg_valid) begin
      if (wait_cnt >= stall) begin
        msg_ready <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // pcsr_link_model

`default_nettype wire

// file: verif/tb_top.sv
// Purpose: Self-checking bench for the slot register bank.
// Assumes: One instance has all three optional capabilities, a second one has none.
// Notes: Registers are reached only through the configuration strobes.
`timescale 1ns/10ps
`default_nettype none
`include "pcsr_defs.svh"

module tb_top
  import pcsr_pkg::*;
;
  logic clk, reset_n, cfg_wr, cfg_rd, cfg_rvalid, link_active, link_change_event;
  logic interlock_toggle, pwr_fault, slot_power_en, spl_msg_valid, spl_msg_ready, tog_seen;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be, stall;
  logic [31:0] cfg_wdata, cfg_rdata, q;
  logic [7:0] spl_msg_value, rx_count, rx_value;
  logic [1:0] rx_scale;
  logic bare_rvalid, bare_tog, bare_pwr;
  logic [31:0] bare_rdata;
  pcsr_scale_type spl_msg_scale;
  int num_errors, n_compared;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and link partner.
  pcsr_regs #(.LINK_ACTIVE_CAP(1'b1), .INTERLOCK_PRESENT(1'b1), .PWR_CTRL_PRESENT(1'b1)) dut (
    .clk(clk), .reset_n(reset_n), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .link_active(link_active), .link_change_event(link_change_event),
    .interlock_toggle(interlock_toggle), .pwr_fault(pwr_fault), .slot_power_en(slot_power_en),
    .spl_msg_valid(spl_msg_valid), .spl_msg_ready(spl_msg_ready),
    .spl_msg_value(spl_msg_value), .spl_msg_scale(spl_msg_scale));
  pcsr_link_model link (
    .clk(clk), .reset_n(reset_n), .msg_valid(spl_msg_valid), .msg_ready(spl_msg_ready),
    .msg_value(spl_msg_value), .msg_scale(spl_msg_scale), .stall(stall),
    .rx_count(rx_count), .rx_value(rx_value), .rx_scale(rx_scale));
  // Bare port with no optional capability; it shares the configuration strobes.
  pcsr_regs dut_bare (
    .clk(clk), .reset_n(reset_n), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(bare_rdata), .cfg_rvalid(bare_rvalid),
    .link_active(link_active), .link_change_event(),
    .interlock_toggle(bare_tog), .pwr_fault(pwr_fault), .slot_power_en(bare_pwr),
    .spl_msg_valid(), .spl_msg_ready(1'b1), .spl_msg_value(), .spl_msg_scale());

  ////////////////////////////////////////////////////////////////////////////////
  // Common tasks.
  task automatic conclude();
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  // One write strobe; the toggle output is sampled in the cycle after it.
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1;
    tog_seen = interlock_toggle;
  endtask

  // A missing answer pulse poisons the data so that the caller's compare fails.
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    q = (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hxxxx_xxxx;
  endtask

  task automatic wait_msgs(input logic [7:0] n);
    for (int i = 0; i < 80 && rx_count !== n; i++) @(posedge clk);
    if (rx_count !== n) begin
      num_errors++;
      conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic sc_reset_values();
    rd(`PCSR_OFF_SLOT_CAP);
    chk(q, `PCSR_CAP_RESET);
    rd(`PCSR_OFF_SLOT_CTL);
    chk(q, 32'h0000_0000);
    rd(12'h0bc);
    chk(q, 32'h0000_0000);
  endtask

  // Each scale code once per reset; read-only bits are written as ones.
  task automatic sc_cap_write();
    logic [31:0] d;
    for (int s = 0; s < 4; s++) begin
      do_reset();
      d = {13'h0a5 + 13'(s), 2'h3, 2'(s), 8'h19 + 8'(s), 7'h7f};
      wr(`PCSR_OFF_SLOT_CAP, 4'hf, d);
      rd(`PCSR_OFF_SLOT_CAP);
      chk(q, (d & 32'hfff9_ff80) | 32'h0004_0000);
      chk(q[6:0], 32'h0);
      wait_msgs(8'h01);
      chk(rx_scale, 32'(s));
      chk(rx_value, 32'(8'h19 + 8'(s)));
    end
  endtask

  // Second write during a slow accept: fields hold, one more message follows.
  task automatic sc_write_once();
    stall <= 4'h6;
    wr(`PCSR_OFF_SLOT_CAP, 4'hf, 32'h0000_0000);
    wr(`PCSR_OFF_SLOT_CAP, 4'hf, 32'h0000_0000);
    wait_msgs(8'h03);
    chk(rx_value, 32'h1c);
    rd(`PCSR_OFF_SLOT_CAP);
    chk(q, 32'h0545_8000 | (32'h0000_001c << 7));
    stall <= 4'h0;
  endtask

  task automatic sc_control();
    chk(slot_power_en, 32'h1);
    wr(`PCSR_OFF_SLOT_CTL, 4'hf, 32'hffff_ffff);
    chk(tog_seen, 32'h1);
    chk(slot_power_en, 32'h0);
    chk(bare_tog, 32'h0);
    chk(bare_pwr, 32'h0);
    rd(`PCSR_OFF_SLOT_CTL);
    chk(q, 32'h0000_1400);
    chk(bare_rvalid, 32'h1);
    chk(bare_rdata, 32'h0000_0000);
    wr(`PCSR_OFF_SLOT_CTL, 4'h2, 32'h0000_0000);
    chk(tog_seen, 32'h0);
    chk(slot_power_en, 32'h1);
    rd(`PCSR_OFF_SLOT_CTL);
    chk(q, 32'h0000_0000);
  endtask

  task automatic sc_fault();
    @(posedge clk);
    pwr_fault <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(slot_power_en, 32'h0);
    @(posedge clk);
    pwr_fault <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(slot_power_en, 32'h0);
    wr(`PCSR_OFF_SLOT_CTL, 4'h2, 32'h0000_0400);
    wr(`PCSR_OFF_SLOT_CTL, 4'h2, 32'h0000_0000);
    chk(slot_power_en, 32'h1);
  endtask

  // One link change with notification on, one with it off.
  task automatic sc_notify();
    int n;
    for (int en = 1; en >= 0; en--) begin
      wr(`PCSR_OFF_SLOT_CTL, 4'h2, 32'(en) << 12);
      n = 0;
      @(posedge clk);
      link_active <= ~link_active;
      for (int i = 0; i < 5; i++) begin
        @(posedge clk);
        #1;
        if (link_change_event === 1'b1) n++;
      end
      chk(32'(n), 32'(en));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {reset_n, cfg_wr, cfg_rd, link_active, pwr_fault, tog_seen} = 6'h00;
    cfg_addr = 12'h000;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
    stall = 4'h0;
    num_errors = 0;
    n_compared = 0;
    do_reset();
    sc_reset_values();
    sc_cap_write();
    sc_write_once();
    sc_control();
    sc_fault();
    sc_notify();
    conclude();
  end
endmodule // tb_top

`default_nettype wire
